// ---- dv/cdt_src_model.sv ----
// Cascade event sources: other timer units and pin events.
// Assumes one-cycle event pulses made on pclk, low when idle.
`include "cdt_defines.svh"
module cdt_src_model
	import cdt_pkg::*;
#(
	parameter int NSRC = `CDT_NSRC
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            fire,
	input  wire logic [6:0]      idx,
	input  wire logic            irq_en,
	output logic      [NSRC-1:0] casc_src
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			casc_src <= '0;
		end else begin
			casc_src <= '0;
			// Source with its irq disabled stays silent
			if (fire && irq_en && idx < NSRC) begin
				casc_src[idx] <= 1'b1;
			end
		end
	end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench of one cascadable down timer over APB.
// Assumes the source model drives every cascade input on pclk.
`include "cdt_defines.svh"
module tb_top
	import cdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic [`CDT_NSRC-1:0] casc_src;
	logic                 status_out;
	logic                 irq_zero;
	logic                 sfire;
	logic [6:0]           sidx;
	logic                 sirq;
	int                   failures;
	int                   checks_done;
	int                   n;
	int                   h;
	int                   fn [5] = '{1, 3, 4, 5, 6};
	logic [31:0]          cv [4] = '{32'h0, 32'h2, 32'h5, 32'h6};
	cdt_timer i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .casc_src(casc_src),
		.status_out(status_out), .irq_zero(irq_zero)
	);
	cdt_src_model i_src (
		.pclk(pclk), .presetn(presetn), .fire(sfire), .idx(sidx),
		.irq_en(sirq), .casc_src(casc_src)
	);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic end_of_test();
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; ends one edge after release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int   k;
		logic r;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Registered answer is read mid-cycle; it stands through the closing edge
		for (k = 0; k < 20; k++) begin
			@(negedge pclk);
			r = pready;
			q = prdata;
			e = pslverr;
			@(posedge pclk);
			if (r === 1'b1) break;
		end
		if (k == 20) begin
			failures++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic fire(input logic [6:0] i);
		sidx <= i;
		sfire <= 1'b1;
		@(posedge pclk);
		sfire <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// Edges from one rise to the next, and high samples among them
	task automatic period(input logic use_irq, output int p_n, output int p_h);
		logic p;
		logic c;
		logic armed;
		int   k;
		p = 1'b1;
		armed = 1'b0;
		p_n = 0;
		p_h = 0;
		// Sampled mid-cycle, away from the edge that updates the outputs
		for (k = 0; k < 400; k++) begin
			@(negedge pclk);
			c = use_irq ? irq_zero : status_out;
			if (c === 1'b1 && p === 1'b0 && armed) break;
			if (c === 1'b1 && p === 1'b0) armed = 1'b1;
			p_n += armed;
			p_h += (armed && c === 1'b1);
			p = c;
		end
		if (k == 400) begin
			failures++;
			end_of_test();
		end
		@(posedge pclk);
	endtask
	function automatic logic f_exp(input int f, input logic [31:0] c);
		case (f)
			3: return c >= 32'h5;
			4: return c < 32'h5 && c >= 32'h2;
			5: return 1'b1;
			6: return c <= 32'h5 && c != 32'h0;
			default: return 1'b0;
		endcase
	endfunction
	initial begin
		{presetn, psel, penable, pwrite, sfire, sirq} = 6'h01;
		{paddr, pwdata, sidx} = '0;
		failures = 0;
		checks_done = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`CDT_OFF_CTRL, 32'h0, 1'b0);
		rd(12'h040, 32'h0, 1'b1);
		wr(`CDT_OFF_CTRL, 32'h1);
		wr(`CDT_OFF_SRC0, 32'h14);
		wr(`CDT_OFF_SRC1, 32'h21);
		wr(`CDT_OFF_SRC2, 32'h6A);
		wr(`CDT_OFF_CASCTL, 32'h115);
		for (int i = 0; i < 2; i++) begin
			fire(i ? 7'h21 : 7'h14);
			rd(`CDT_OFF_CTRL, 32'h3, 1'b0);
			fire(7'h6A);
			rd(`CDT_OFF_CTRL, 32'h1, 1'b0);
		end
		fire(7'h14);
		wr(`CDT_OFF_COUNT, 32'hA);
		repeat (4) fire(7'h14);
		rd(`CDT_OFF_COUNT, 32'h6, 1'b0);
		sirq <= 1'b0;
		fire(7'h14);
		rd(`CDT_OFF_COUNT, 32'h6, 1'b0);
		wr(`CDT_OFF_CASCTL, 32'h0);
		wr(`CDT_OFF_RELOAD, 32'h6);
		rd(`CDT_OFF_RELOAD, 32'h6, 1'b0);
		wr(`CDT_OFF_CTRL, 32'h13);
		period(1'b0, n, h);
		chk(n, 32'h7);
		chk(h, 32'h1);
		period(1'b1, n, h);
		chk(n, 32'h7);
		chk(h, 32'h1);
		wr(`CDT_OFF_CTRL, 32'h53);
		period(1'b0, n, h);
		chk(n, 32'hE);
		chk(h, 32'h7);
		wr(`CDT_OFF_CMPA, 32'h5);
		wr(`CDT_OFF_CMPB, 32'h2);
		foreach (fn[i]) begin
			foreach (cv[j]) begin
				wr(`CDT_OFF_CTRL, 32'h1 | (32'(fn[i]) << 5));
				wr(`CDT_OFF_COUNT, cv[j]);
				repeat (2) @(posedge pclk);
				chk(32'(status_out), 32'(f_exp(fn[i], cv[j])));
			end
		end
		wr(`CDT_OFF_CTRL, 32'h23);
		chk(32'(status_out), 32'h1);
		wr(`CDT_OFF_CTRL, 32'h123);
		chk(32'(status_out), 32'h0);
		wr(`CDT_OFF_ENABLE, 32'h0);
		rd(`CDT_OFF_CTRL, 32'h122, 1'b0);
		wr(`CDT_OFF_COUNT, 32'h3);
		// Auto bits stop the unit at the first zero
		wr(`CDT_OFF_CTRL, 32'hF);
		repeat (4) @(posedge pclk);
		rd(`CDT_OFF_CTRL, 32'hC, 1'b0);
		rd(`CDT_OFF_COUNT, 32'h0, 1'b0);
		// Inverted idle halt source stops the active unit
		wr(`CDT_OFF_CTRL, 32'h3);
		wr(`CDT_OFF_CASCTL, 32'h300);
		rd(`CDT_OFF_CTRL, 32'h1, 1'b0);
		end_of_test();
	end
endmodule

// ---- logic/cdt_timer.sv ----
// One cascadable down timer unit with an APB register file.
// Assumes cascade sources come from logic on pclk (already synchronised).
// Notes on behaviour
// - Thirty-two bit counter decrements toward zero, making and measuring events.
// - No prescaler; in cascade count mode decrement exactly one per event.
// - Each cascade input selects one of up to 107 event sources.
// - Enabled cascade inputs zero and one start the unit's counting.
// - Cascade input two halts the unit's activity.
// - Interrupt request is raised while the counter equals zero.
// - Cascade control plus three source selects decide which signals feed in.
// - Function 0 gives a one-cycle pulse when the counter reaches zero.
// - Function 1 shows the active bit.
// - Function 2 toggles on every zero, a 50 percent square wave.
// - Function 3 is high while counter is at or above compare A.
// - Function 4 is high while counter is below A and at least B.
// - Function 5 shows the enabled bit.
// - Function 6 is high while counter is at most A and above zero.
`include "cdt_defines.svh"
module cdt_timer
	import cdt_pkg::*;
#(
	parameter int NSRC = `CDT_NSRC,
	parameter int AW   = 12
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [AW-1:0]   paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [NSRC-1:0] casc_src,
	output logic                 status_out,
	output logic                 irq_zero
);

	cdt_state_s q;
	cdt_state_s s;
	logic [2:0] lvl;
	logic [2:0] evt;
	logic       wr;
	logic       tick;
	logic       reach0;
	logic       hit;
	logic [11:0] a;

	function automatic logic pick(input logic [NSRC-1:0] v, input logic [`CDT_SEL_W-1:0] sel);
		// Codes past the last source read as an idle input
		if (32'(sel) < NSRC) begin
			return v[sel];
		end
		return 1'b0;
	endfunction

	always_comb begin
		s = q;
		a = 12'(paddr);
		wr = psel & penable & q.pready & pwrite;
		// Cascade: selected source, optional invert, level or rising edge
		for (int i = 0; i < 3; i++) begin
			lvl[i] = pick(casc_src, q.casc[i].sel) ^ q.casc[i].inv;
			evt[i] = q.casc[i].en & (q.casc[i].trg ? (lvl[i] & ~q.casc_lvl[i]) : lvl[i]);
		end
		s.casc_lvl = lvl;
		tick = q.en & q.act & (q.cnt_src ? evt[0] : 1'b1);
		reach0 = tick & (q.cnt == 32'h00000001);
		if (tick) begin
			if (q.cnt == 32'h00000000) begin
				s.cnt = q.reload;
			end else begin
				s.cnt = q.cnt - 32'h00000001;
			end
		end
		if (reach0) begin
			s.toggle = ~q.toggle;
			if (q.auto_dis) begin
				s.en = 1'b0;
			end
			if (q.auto_deact) begin
				s.act = 1'b0;
			end
		end
		if (q.en & (evt[0] | evt[1])) begin
			s.act = 1'b1;
		end
		// Halt beats a start in the same cycle, as an emergency stop must
		if (evt[2]) begin
			s.act = 1'b0;
		end
		// Software writes land last and override hardware updates
		if (wr) begin
			unique case (a)
				`CDT_OFF_CTRL: begin
					s.en = pwdata[`CDT_CTRL_EN];
					s.act = pwdata[`CDT_CTRL_ACT];
					s.auto_dis = pwdata[`CDT_CTRL_AUTODIS];
					s.auto_deact = pwdata[`CDT_CTRL_AUTODEA];
					s.irq_en = pwdata[`CDT_CTRL_IRQEN];
					s.out_sel = cdt_out_e'(pwdata[`CDT_CTRL_SEL]);
					s.out_inv = pwdata[`CDT_CTRL_INV];
				end
				`CDT_OFF_RELOAD: s.reload = pwdata;
				`CDT_OFF_COUNT:  s.cnt = pwdata;
				`CDT_OFF_ENABLE: s.en = pwdata[0];
				`CDT_OFF_CASCTL: begin
					s.casc[0].en = pwdata[`CDT_CSD_EN0];
					s.casc[0].inv = pwdata[`CDT_CSD_INV0];
					s.casc[0].trg = pwdata[`CDT_CSD_TRG0];
					s.casc[1].en = pwdata[`CDT_CSD_EN1];
					s.casc[1].inv = pwdata[`CDT_CSD_INV1];
					s.casc[1].trg = pwdata[`CDT_CSD_TRG1];
					s.casc[2].en = pwdata[`CDT_CSD_EN2];
					s.casc[2].inv = pwdata[`CDT_CSD_INV2];
					s.casc[2].trg = pwdata[`CDT_CSD_TRG2];
					s.cnt_src = pwdata[`CDT_CSD_CNTSRC];
				end
				`CDT_OFF_SRC0: s.casc[0].sel = pwdata[`CDT_SEL_W-1:0];
				`CDT_OFF_SRC1: s.casc[1].sel = pwdata[`CDT_SEL_W-1:0];
				`CDT_OFF_SRC2: s.casc[2].sel = pwdata[`CDT_SEL_W-1:0];
				`CDT_OFF_CMPA: s.cmp_a = pwdata;
				`CDT_OFF_CMPB: s.cmp_b = pwdata;
				default: ;
			endcase
		end
		// Status function built from next state so the pin stays a flop
		unique case (s.out_sel)
			CDT_OUT_ZERO_PULSE: hit = reach0;
			CDT_OUT_ACTIVE:     hit = s.act;
			CDT_OUT_TOGGLE:     hit = s.toggle;
			CDT_OUT_CMP_A:      hit = s.cnt >= s.cmp_a;
			CDT_OUT_CMP_AB:     hit = (s.cnt < s.cmp_a) && (s.cnt >= s.cmp_b);
			CDT_OUT_ENABLED:    hit = s.en;
			CDT_OUT_CMP_A_NZ:   hit = (s.cnt <= s.cmp_a) && (s.cnt != 32'h00000000);
			default:            hit = 1'b0;
		endcase
		s.status = hit ^ s.out_inv;
		s.irq = s.irq_en & (s.cnt == 32'h00000000);
		// Zero wait states: answer prepared in setup, shown in access
		s.pready = psel & ~penable;
		s.pslverr = 1'b0;
		s.prdata = `CDT_RST_WORD;
		if (psel & ~penable) begin
			unique case (a)
				`CDT_OFF_CTRL: begin
					s.prdata[`CDT_CTRL_EN] = q.en;
					s.prdata[`CDT_CTRL_ACT] = q.act;
					s.prdata[`CDT_CTRL_AUTODIS] = q.auto_dis;
					s.prdata[`CDT_CTRL_AUTODEA] = q.auto_deact;
					s.prdata[`CDT_CTRL_IRQEN] = q.irq_en;
					s.prdata[`CDT_CTRL_SEL] = q.out_sel;
					s.prdata[`CDT_CTRL_INV] = q.out_inv;
				end
				`CDT_OFF_RELOAD: s.prdata = q.reload;
				`CDT_OFF_COUNT:  s.prdata = q.cnt;
				`CDT_OFF_ENABLE: s.prdata[0] = q.en;
				`CDT_OFF_CASCTL: begin
					s.prdata[`CDT_CSD_EN0] = q.casc[0].en;
					s.prdata[`CDT_CSD_INV0] = q.casc[0].inv;
					s.prdata[`CDT_CSD_TRG0] = q.casc[0].trg;
					s.prdata[`CDT_CSD_EN1] = q.casc[1].en;
					s.prdata[`CDT_CSD_INV1] = q.casc[1].inv;
					s.prdata[`CDT_CSD_TRG1] = q.casc[1].trg;
					s.prdata[`CDT_CSD_EN2] = q.casc[2].en;
					s.prdata[`CDT_CSD_INV2] = q.casc[2].inv;
					s.prdata[`CDT_CSD_TRG2] = q.casc[2].trg;
					s.prdata[`CDT_CSD_CNTSRC] = q.cnt_src;
				end
				`CDT_OFF_SRC0: s.prdata[`CDT_SEL_W-1:0] = q.casc[0].sel;
				`CDT_OFF_SRC1: s.prdata[`CDT_SEL_W-1:0] = q.casc[1].sel;
				`CDT_OFF_SRC2: s.prdata[`CDT_SEL_W-1:0] = q.casc[2].sel;
				`CDT_OFF_CMPA: s.prdata = q.cmp_a;
				`CDT_OFF_CMPB: s.prdata = q.cmp_b;
				default:       s.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= s;
		end
	end

	assign prdata     = q.prdata;
	assign pready     = q.pready;
	assign pslverr    = q.pslverr;
	assign status_out = q.status;
	// Cascade event to other units exists only while the request is enabled
	assign irq_zero   = q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_free_decrement: assert property (
		(tick && !q.cnt_src && q.cnt != 32'h00000000 && !wr) |=> q.cnt == $past(q.cnt) - 32'h00000001
	) else $error("counter did not step down by one");

	chk_cascade_hold: assert property (
		(q.en && q.act && q.cnt_src && !evt[0] && !wr) |=> $stable(q.cnt)
	) else $error("counter moved without a cascade event");

	chk_src_range: assert property (
		(32'(q.casc[2].sel) >= NSRC && !q.casc[2].inv) |-> !evt[2]
	) else $error("out-of-range source produced an event");

	chk_start_act: assert property (
		(q.en && !q.act && evt[1] && !evt[2] && !wr) |=> q.act
	) else $error("start event did not activate the unit");

	chk_halt_act: assert property (
		(evt[2] && !wr) |=> !q.act ##1 (q.act || !tick)
	) else $error("halt event did not stop the unit");

	chk_irq_zero: assert property (
		irq_zero == (q.irq_en && q.cnt == 32'h00000000)
	) else $error("interrupt request disagrees with counter");

	chk_zero_pulse: assert property (
		(reach0 && !wr && q.out_sel == CDT_OUT_ZERO_PULSE && !q.out_inv) |=> status_out
	) else $error("no pulse when counter reached zero");

	chk_toggle_zero: assert property (
		(reach0 && !wr) |=> q.toggle != $past(q.toggle)
	) else $error("toggle did not flip at zero");

	chk_cmp_a_level: assert property (
		(q.out_sel == CDT_OUT_CMP_A && !q.out_inv) |-> status_out == (q.cnt >= q.cmp_a)
	) else $error("compare A output wrong");

	chk_reload_zero: assert property (
		(tick && q.cnt == 32'h00000000 && !wr) |=> q.cnt == $past(q.reload)
	) else $error("counter did not reload after zero");

	chk_active_out: assert property (
		(q.out_sel == CDT_OUT_ACTIVE && !q.out_inv) |-> status_out == q.act
	) else $error("status does not show the active bit");

	chk_toggle_out: assert property (
		(q.out_sel == CDT_OUT_TOGGLE && !q.out_inv) |-> status_out == q.toggle
	) else $error("status does not follow the toggle");

	chk_ab_window: assert property (
		(q.out_sel == CDT_OUT_CMP_AB && !q.out_inv) |->
			status_out == ((q.cnt < q.cmp_a) && (q.cnt >= q.cmp_b))
	) else $error("compare window output wrong");

	chk_enabled_out: assert property (
		(q.out_sel == CDT_OUT_ENABLED && !q.out_inv) |-> status_out == q.en
	) else $error("status does not show the enabled bit");

	chk_a_nonzero: assert property (
		(q.out_sel == CDT_OUT_CMP_A_NZ && !q.out_inv) |->
			status_out == ((q.cnt <= q.cmp_a) && (q.cnt != 32'h00000000))
	) else $error("compare A above zero output wrong");

	chk_pulse_only_zero: assert property (
		(q.out_sel == CDT_OUT_ZERO_PULSE && !q.out_inv && !reach0 && !wr) |=> !status_out
	) else $error("zero pulse outside a transition to zero");

	chk_reach_zero_cnt: assert property (
		(reach0 && !wr) |=> q.cnt == 32'h00000000
	) else $error("counter did not land on zero");

	chk_no_start_disabled: assert property (
		(!q.en && !q.act && !wr) |=> !q.act
	) else $error("disabled unit became active");

	chk_halt_beats_start: assert property (
		(evt[2] && evt[0] && q.en && !wr) |=> !q.act
	) else $error("start won over a halt");

	chk_stay_halted: assert property (
		(!q.act && !wr && !evt[0] && !evt[1]) |=> !q.act
	) else $error("unit resumed without a start");

	chk_select_source: assert property (
		(q.casc[0].en && !q.casc[0].trg && !q.casc[0].inv && 32'(q.casc[0].sel) < NSRC &&
			casc_src[q.casc[0].sel]) |-> evt[0]
	) else $error("selected source gave no event");

	chk_casc_disabled: assert property (
		!q.casc[2].en |-> !evt[2]
	) else $error("disabled cascade input gave an event");

	chk_irq_off: assert property (
		!q.irq_en |-> !irq_zero
	) else $error("interrupt request without enable");

	chk_ready_pulse: assert property (
		pready |=> !pready
	) else $error("ready stood longer than one cycle");

	chk_err_with_ready: assert property (
		pslverr |-> pready
	) else $error("error without ready");

	cov_reach_zero: cover property (reach0 ##1 tick);
	cov_halt_start: cover property (evt[2] ##[1:20] (evt[0] && q.en));
	cov_casc_count: cover property (q.cnt_src && tick);
	cov_ab_window: cover property (q.out_sel == CDT_OUT_CMP_AB && status_out);
	cov_a_nz_window: cover property (q.out_sel == CDT_OUT_CMP_A_NZ && status_out);

endmodule

// ---- pkg/cdt_defines.svh ----
// Offsets, field positions and reset values of one cascadable down timer.
// Assumes a 32-bit APB slave, one aligned word per register.
`ifndef CDT_DEFINES_SVH
`define CDT_DEFINES_SVH

`define CDT_CNT_W        32
`define CDT_SEL_W        7
`define CDT_NSRC         107

`define CDT_OFF_CTRL     12'h000
`define CDT_OFF_RELOAD   12'h004
`define CDT_OFF_COUNT    12'h008
`define CDT_OFF_ENABLE   12'h00C
`define CDT_OFF_CASCTL   12'h010
`define CDT_OFF_SRC0     12'h014
`define CDT_OFF_SRC1     12'h018
`define CDT_OFF_SRC2     12'h01C
`define CDT_OFF_CMPA     12'h020
`define CDT_OFF_CMPB     12'h024

`define CDT_CTRL_EN      0
`define CDT_CTRL_ACT     1
`define CDT_CTRL_AUTODIS 2
`define CDT_CTRL_AUTODEA 3
`define CDT_CTRL_IRQEN   4
`define CDT_CTRL_SEL     7:5
`define CDT_CTRL_INV     8

`define CDT_CSD_EN0      0
`define CDT_CSD_INV0     1
`define CDT_CSD_EN1      2
`define CDT_CSD_INV1     3
`define CDT_CSD_CNTSRC   4
`define CDT_CSD_TRG0     6
`define CDT_CSD_TRG1     7
`define CDT_CSD_EN2      8
`define CDT_CSD_INV2     9
`define CDT_CSD_TRG2     10

`define CDT_RST_WORD     32'h00000000

`endif

// ---- pkg/cdt_pkg.sv ----
// Types of the cascadable down timer: output function codes and state carrier.
// Assumes cdt_defines.svh for widths.
`include "cdt_defines.svh"
package cdt_pkg;

	typedef enum logic [2:0] {
		CDT_OUT_ZERO_PULSE,
		CDT_OUT_ACTIVE,
		CDT_OUT_TOGGLE,
		CDT_OUT_CMP_A,
		CDT_OUT_CMP_AB,
		CDT_OUT_ENABLED,
		CDT_OUT_CMP_A_NZ
	} cdt_out_e;

	typedef struct packed {
		logic                  en;
		logic                  inv;
		logic                  trg;
		logic [`CDT_SEL_W-1:0] sel;
	} cdt_casc_s;

	typedef struct packed {
		logic                  en;
		logic                  act;
		logic                  auto_dis;
		logic                  auto_deact;
		logic                  irq_en;
		cdt_out_e              out_sel;
		logic                  out_inv;
		logic                  cnt_src;
		cdt_casc_s [2:0]       casc;
		logic [2:0]            casc_lvl;
		logic [`CDT_CNT_W-1:0] reload;
		logic [`CDT_CNT_W-1:0] cnt;
		logic [`CDT_CNT_W-1:0] cmp_a;
		logic [`CDT_CNT_W-1:0] cmp_b;
		logic                  toggle;
		logic                  status;
		logic                  irq;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} cdt_state_s;

endpackage
